/* src/tid_pkg.sv */
package tid_pkg;

    // Register byte offsets; every printed offset is word aligned.
    localparam logic [11:0] TID_P1_KEY_COUNT_OFS  = 12'h188;
    localparam logic [11:0] TID_SPECIAL_P1_OFS    = 12'h18C;
    localparam logic [11:0] TID_RSVD_WORD_A_OFS   = 12'h190;
    localparam logic [11:0] TID_RSVD_WORD_B_OFS   = 12'h194;
    localparam logic [11:0] TID_CUSTOM_FEAT_OFS   = 12'h1C0;
    localparam logic [11:0] TID_CAPABILITY_OFS    = 12'h1E0;

    // Fixed values of the reserved and key count words.
    localparam logic [31:0] TID_P1_KEY_COUNT_VAL  = 32'h0000_0000;
    localparam logic [31:0] TID_SPECIAL_P1_VAL    = 32'h0000_0000;
    localparam logic [31:0] TID_RSVD_WORD_VAL     = 32'h0000_0000;

    // Custom feature control layout.
    localparam int          TID_FEAT_SUPPORT_LSB  = 0;
    localparam int          TID_FEAT_EN_LSB       = 4;
    localparam logic [3:0]  TID_FEAT_SUPPORT_VAL  = 4'h0;
    localparam logic [3:0]  TID_FEAT_EN_RST       = 4'h0;

    // Capability word fields.
    localparam int          TID_TXN_START_BIT     = 30;
    localparam int          TID_COMMIT_MODE_BIT   = 29;
    localparam int          TID_TS_WIDTH_LSB      = 24;
    localparam int          TID_Q_SUPPORT_LSB     = 15;
    localparam int          TID_Q_FILTER_BIT      = 14;
    localparam int          TID_EVENT_COUNT_LSB   = 10;
    localparam int          TID_RET_STACK_BIT     = 9;
    localparam int          TID_CYCLE_COUNT_BIT   = 7;
    localparam int          TID_BRANCH_BCAST_BIT  = 5;
    localparam int          TID_RES1_BIT          = 0;
    localparam logic [4:0]  TID_TS_WIDTH_64       = 5'h08;
    localparam logic [1:0]  TID_Q_SUPPORT_NONE    = 2'h0;
    localparam logic [1:0]  TID_EVENT_COUNT_FOUR  = 2'h3;

    // AXI response codes.
    localparam logic [1:0]  TID_RESP_OKAY         = 2'h0;
    localparam logic [1:0]  TID_RESP_SLVERR       = 2'h2;

    // Assembled capability word; reserved bits stay zero except bit 0, which is set to one.
    localparam logic [31:0] TID_CAPABILITY_VAL    =
        (32'h0000_0000 << TID_TXN_START_BIT)
      | (32'h0000_0001 << TID_COMMIT_MODE_BIT)
      | ({27'h0, TID_TS_WIDTH_64} << TID_TS_WIDTH_LSB)
      | ({30'h0, TID_Q_SUPPORT_NONE} << TID_Q_SUPPORT_LSB)
      | (32'h0000_0000 << TID_Q_FILTER_BIT)
      | ({30'h0, TID_EVENT_COUNT_FOUR} << TID_EVENT_COUNT_LSB)
      | (32'h0000_0001 << TID_RET_STACK_BIT)
      | (32'h0000_0001 << TID_CYCLE_COUNT_BIT)
      | (32'h0000_0001 << TID_BRANCH_BCAST_BIT)
      | (32'h0000_0001 << TID_RES1_BIT);

endpackage

/* src/tid_regs.sv */
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
// Function
// - Word at 0x188 reports P1 key count; data tracing absent, reads zero.
// - Word at 0x18C reports special P1 key count; reserved, reads zero.
// - Words at 0x190 and 0x194 are reserved, reset and read as zero.
// - Custom feature word bits 3:0 read zero; bits 31:8 read zero.
// - Custom feature bits 7:4 enable features; zero means features absent.
// - Capability bit 30 reads zero: transaction start elements are P0.
// - Capability bit 29 reads one: commit mode 1 for cycle count packets.
// - Capability bits 28:24 report global timestamp of 64 bits.
// - Capability bits 16:14 read zero: no Q element support or filtering.
// - Capability bits 11:10 read binary 11: four trace events.
// - Capability bit 9 reads one: return stack supported.
// - Capability bit 7 reads one: cycle counting supported.
module tid_regs
    import tid_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic [2:0]        s_axi_awprot_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic [2:0]        s_axi_arprot_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic [3:0]             feature_enable_o,
    output logic                   feature_active_o
);

    // The decoder compares twelve address bits, so narrower buses cannot reach the map.
    generate
        if (ADDR_W < 12 || ADDR_W > 32)
        begin : g_addr_check
            $error("tid_regs: ADDR_W must lie between 12 and 32");
        end
    endgenerate

    // All state of the block in one record.
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [3:0]        feat_en;
        logic              feat_active;
    } tid_state_s;

    tid_state_s state_ff;
    tid_state_s nxt_state;

    // Word select ignores the two byte bits, since every register is one aligned word.
    function automatic logic [11:0] word_addr(input logic [ADDR_W-1:0] addr);
        word_addr = {addr[11:2], 2'b00};
    endfunction

    // Upper address bits above the map must be zero for a hit.
    function automatic logic upper_clear(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] masked;
        masked = addr;
        masked[11:0] = 12'h000;
        upper_clear = (masked == '0);
    endfunction

    // True for any of the six mapped words; shared by read and write paths.
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [11:0] wa;
        wa = word_addr(addr);
        is_mapped = 1'b0;
        if (!upper_clear(addr))
        begin
            is_mapped = 1'b0;
        end
        else if (wa == TID_P1_KEY_COUNT_OFS || wa == TID_SPECIAL_P1_OFS)
        begin
            is_mapped = 1'b1;
        end
        else if (wa == TID_RSVD_WORD_A_OFS || wa == TID_RSVD_WORD_B_OFS)
        begin
            is_mapped = 1'b1;
        end
        else if (wa == TID_CUSTOM_FEAT_OFS || wa == TID_CAPABILITY_OFS)
        begin
            is_mapped = 1'b1;
        end
    endfunction

    // Read value of a mapped word; unmapped words give zero.
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                              input logic [3:0]        en);
        logic [11:0] wa;
        logic [31:0] feat;
        wa = word_addr(addr);
        feat = 32'h0000_0000;
        feat[TID_FEAT_SUPPORT_LSB +: 4] = TID_FEAT_SUPPORT_VAL;
        feat[TID_FEAT_EN_LSB +: 4] = en;
        read_word = 32'h0000_0000;
        if (!upper_clear(addr))
        begin
            read_word = 32'h0000_0000;
        end
        else if (wa == TID_P1_KEY_COUNT_OFS)
        begin
            read_word = TID_P1_KEY_COUNT_VAL;
        end
        else if (wa == TID_SPECIAL_P1_OFS)
        begin
            read_word = TID_SPECIAL_P1_VAL;
        end
        else if (wa == TID_RSVD_WORD_A_OFS || wa == TID_RSVD_WORD_B_OFS)
        begin
            read_word = TID_RSVD_WORD_VAL;
        end
        else if (wa == TID_CUSTOM_FEAT_OFS)
        begin
            read_word = feat;
        end
        else if (wa == TID_CAPABILITY_OFS)
        begin
            // Constant word carries fields.
            read_word = TID_CAPABILITY_VAL;
        end
    endfunction

    // Protection attributes are accepted but do not restrict access.
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot_i, s_axi_arprot_i};

    // Next-state logic for both channels and the enable field.
    always_comb
    begin
        logic aw_fire;
        logic w_fire;
        logic ar_fire;
        logic do_write;
        logic [11:0] wa;
        aw_fire = 1'b0;
        w_fire = 1'b0;
        ar_fire = 1'b0;
        do_write = 1'b0;
        wa = 12'h000;
        nxt_state = state_ff;

        // Write address and data are captured independently, in either order.
        aw_fire = state_ff.awready && s_axi_awvalid_i;
        w_fire = state_ff.wready && s_axi_wvalid_i;
        if (aw_fire)
        begin
            nxt_state.aw_held = 1'b1;
            nxt_state.awaddr = s_axi_awaddr_i;
        end
        if (w_fire)
        begin
            nxt_state.w_held = 1'b1;
            nxt_state.wdata = s_axi_wdata_i;
            nxt_state.wstrb = s_axi_wstrb_i;
        end

        // Retire the response; a new one cannot start until the next cycle, since commit checks the registered bvalid.
        if (state_ff.bvalid && s_axi_bready_i)
        begin
            nxt_state.bvalid = 1'b0;
        end

        // Commit once both halves are held and no response is still pending.
        if (state_ff.aw_held && state_ff.w_held && !state_ff.bvalid)
        begin
            do_write = 1'b1;
            nxt_state.aw_held = 1'b0;
            nxt_state.w_held = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = is_mapped(state_ff.awaddr) ? TID_RESP_OKAY : TID_RESP_SLVERR;
        end

        // Only the enable nibble takes a write; fixed words drop it silently.
        wa = word_addr(state_ff.awaddr);
        if (do_write && upper_clear(state_ff.awaddr) && wa == TID_CUSTOM_FEAT_OFS)
        begin
            if (state_ff.wstrb[0])
            begin
                nxt_state.feat_en = state_ff.wdata[TID_FEAT_EN_LSB +: 4];
            end
        end

        // Enabled features only take effect where support exists, and none does.
        nxt_state.feat_active = (|nxt_state.feat_en) && (|TID_FEAT_SUPPORT_VAL);

        // Readies are registered, so they drop as soon as a half is held.
        nxt_state.awready = !nxt_state.aw_held;
        nxt_state.wready = !nxt_state.w_held;

        // Read channel: one read at a time, answered one cycle after the address.
        if (state_ff.rvalid && s_axi_rready_i)
        begin
            nxt_state.rvalid = 1'b0;
        end
        ar_fire = state_ff.arready && s_axi_arvalid_i;
        if (ar_fire)
        begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rdata = read_word(s_axi_araddr_i, state_ff.feat_en);
            nxt_state.rresp = is_mapped(s_axi_araddr_i) ? TID_RESP_OKAY : TID_RESP_SLVERR;
        end
        nxt_state.arready = !nxt_state.rvalid;

        // Synchronous reset gives every field its defined value.
        if (!rst_n_i)
        begin
            nxt_state = '0;
            nxt_state.feat_en = TID_FEAT_EN_RST;
            nxt_state.bresp = TID_RESP_OKAY;
            nxt_state.rresp = TID_RESP_OKAY;
        end
    end

    // Single register stage for the whole record.
    always_ff @(posedge clock_i)
    begin
        state_ff <= nxt_state;
    end

    // Every output is a field of the registered record.
    assign s_axi_awready_o = state_ff.awready;
    assign s_axi_wready_o = state_ff.wready;
    assign s_axi_bvalid_o = state_ff.bvalid;
    assign s_axi_bresp_o = state_ff.bresp;
    assign s_axi_arready_o = state_ff.arready;
    assign s_axi_rvalid_o = state_ff.rvalid;
    assign s_axi_rdata_o = state_ff.rdata;
    assign s_axi_rresp_o = state_ff.rresp;
    assign feature_enable_o = state_ff.feat_en;
    assign feature_active_o = state_ff.feat_active;

endmodule

/* verif/tid_axi_master.sv */
`timescale 1ns/1ps
// Debugger stand-in: one write or read at a time, waiting as long as the slave takes.
module tid_axi_master
(
    input  wire logic   clock_i,
    input  wire logic   awready_i,
    input  wire logic   wready_i,
    input  wire logic   bvalid_i,
    input  wire logic   arready_i,
    input  wire logic   rvalid_i,
    output logic [11:0] awaddr_o,
    output logic        awvalid_o,
    output logic [31:0] wdata_o,
    output logic [3:0]  wstrb_o,
    output logic        wvalid_o,
    output logic        bready_o,
    output logic [11:0] araddr_o,
    output logic        arvalid_o,
    output logic        rready_o
);
    // Idle at time zero so no handshake is ever sampled unknown.
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end

    // Each half drops on its own take; address and data are inverted once both are taken, strobes held.
    task automatic write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clock_i);
        {awaddr_o, wdata_o, wstrb_o} <= {a, d, s};
        {awvalid_o, wvalid_o, bready_o} <= 3'h7;
        while (pa || pw)
        begin
            @(posedge clock_i);
            pa = pa && !awready_i;
            pw = pw && !wready_i;
            awvalid_o <= pa;
            wvalid_o <= pw;
        end
        {awaddr_o, wdata_o} <= {~a, ~d};
        while (!bvalid_i)
            @(posedge clock_i);
        bready_o <= 1'b0;
    endtask

    task automatic read(input logic [11:0] a);
        @(posedge clock_i);
        araddr_o <= a;
        {arvalid_o, rready_o} <= 2'h3;
        do
            @(posedge clock_i);
        while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
        while (!rvalid_i)
            @(posedge clock_i);
        rready_o <= 1'b0;
    endtask
endmodule

/* verif/tid_regs_asserts.sv */
`timescale 1ns/1ps
// Fixed register values and enable behaviour, checked at the ports.
module tid_regs_asserts
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              clock_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic [31:0]       s_axi_wdata_i,
    input wire logic [3:0]        s_axi_wstrb_i,
    input wire logic              s_axi_wvalid_i,
    input wire logic              s_axi_wready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic [1:0]        s_axi_rresp_o,
    input wire logic [3:0]        feature_enable_o,
    input wire logic              feature_active_o
);
    // Take strobes; a write counts only when both halves go on one edge.
    wire logic        rd = s_axi_arvalid_i && s_axi_arready_o;
    wire logic        wt = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    wire logic        rc = rd && s_axi_araddr_i == 'h1E0;
    wire logic        rf = rd && s_axi_araddr_i == 'h1C0;
    wire logic [31:0] q  = s_axi_rdata_o;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    key_count_zero_a: assert property (rd && s_axi_araddr_i[11:3] == 9'h31 |=> q == 0)
        else $error("key count word not zero");
    rsvd_word_zero_a: assert property (rd && s_axi_araddr_i[11:3] == 9'h32 |=> q == 0)
        else $error("reserved word not zero");
    feat_fixed_bits_a: assert property (rf |=> q[3:0] == 0 && q[31:8] == 0)
        else $error("feature word fixed bits wrong");
    feat_inactive_a: assert property (!feature_active_o)
        else $error("feature active without support");
    feat_write_a: assert property (wt && s_axi_awaddr_i == 'h1C0 && s_axi_wstrb_i[0]
        |-> ##2 feature_enable_o == $past(s_axi_wdata_i[7:4], 2)) else $error("enable not stored");
    cap_txn_start_a: assert property (rc |=> !q[30])
        else $error("cap bit 30");
    cap_commit_a: assert property (rc ##1 1 |-> q[29])
        else $error("cap bit 29");
    cap_ts_width_a: assert property (rc |=> q[28:24] == 5'h08)
        else $error("cap timestamp width");
    cap_no_q_a: assert property (rc |=> q[16:14] == 3'h0)
        else $error("cap q bits");
    cap_events_a: assert property (rc |=> q[11:10] == 2'h3)
        else $error("cap event count");
    cap_ret_stack_a: assert property ($past(rc) |-> q[9])
        else $error("cap bit 9");
    cap_cycle_cnt_a: assert property (rc |=> q[7])
        else $error("cap bit 7");
    cap_reserved_a: assert property (rc |=> (q & 32'h80FE_3100) == 0 && s_axi_rresp_o == 0)
        else $error("cap reserved bits");
endmodule

bind tid_regs tid_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.clock_i, .rst_n_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .feature_enable_o, .feature_active_o);

/* verif/tid_regs_tb.sv */
`timescale 1ns/1ps
// Expectations go into a queue in issue order; the monitor retires them per response.
module tid_regs_tb;
    import tid_pkg::*;
    logic        clock_i, rst_n_i, feature_active_o;
    logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, seed, d;
    logic [3:0]  s_axi_wstrb_i, feature_enable_o, en;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
    logic        s_axi_rvalid_o, s_axi_rready_i;
    logic [33:0] exp_q[$];
    logic [11:0] ofs[6] = '{12'h188, 12'h18C, 12'h190, 12'h194, 12'h1C0, 12'h1E0};
    int          num_errors, tests_run;

    tid_regs #(.ADDR_W(12)) u_dut (.clock_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awprot_i(3'h0),
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .feature_enable_o, .feature_active_o);

    tid_axi_master u_mst (.clock_i, .awready_i(s_axi_awready_o), .wready_i(s_axi_wready_o),
        .bvalid_i(s_axi_bvalid_o), .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o),
        .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i), .wdata_o(s_axi_wdata_i),
        .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i), .bready_o(s_axi_bready_i),
        .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .rready_o(s_axi_rready_i));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Capability: bits 29, 28:24 = 8, 11:10 = 3, 9 and 7, plus bits 5 and 0 fixed high.
    function automatic logic [31:0] exp_val(input int i);
        if (i == 5)
            return 32'h2800_0EA1;
        return (i == 4) ? {24'h0, en, 4'h0} : 32'h0;
    endfunction

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        u_mst.write(a, v, s);
    endtask

    task automatic rd(input logic [11:0] a, input logic [1:0] r, input int i);
        exp_q.push_back({r, (i < 0) ? 32'h0 : exp_val(i)});
        u_mst.read(a);
    endtask

    task automatic final_report();
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Each completed response retires the oldest expectation.
    always @(posedge clock_i)
    begin
        if (s_axi_rvalid_o && s_axi_rready_i)
            chk({s_axi_rresp_o, s_axi_rdata_o}, exp_q.pop_front());
        if (s_axi_bvalid_o && s_axi_bready_i)
            chk({s_axi_bresp_o, 32'h0}, exp_q.pop_front());
    end

    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
    initial
    begin
        repeat (3000) @(posedge clock_i);
        num_errors++;
        final_report();
    end

    initial
    begin
        {rst_n_i, num_errors, tests_run, en, seed} = {1'b0, 32'h0, 32'h0, 4'h0, 32'd94};
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd(ofs[i], TID_RESP_OKAY, i);
            if (i != 4)
                wr(ofs[i], rnd(), 4'hF, TID_RESP_OKAY);
            rd(ofs[i], TID_RESP_OKAY, i);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = rnd();
            wr(12'h1C0, d, 4'hF, TID_RESP_OKAY);
            en = d[7:4];
            chk({29'h0, feature_active_o, feature_enable_o}, {30'h0, en});
            wr(12'h1C0, ~d, 4'hE, TID_RESP_OKAY);
            rd(12'h1C0, TID_RESP_OKAY, 4);
        end
        wr(12'h198, rnd(), 4'hF, TID_RESP_SLVERR);
        rd(12'h1FC, TID_RESP_SLVERR, -1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        en = 4'h0;
        rd(12'h1C0, TID_RESP_OKAY, 4);
        repeat (2) @(posedge clock_i);
        final_report();
    end
endmodule
